// ==== rtl/uce_ctrl.v ====
// Endpoint zero configuration, byte count and handshake control
`timescale 1ns/1ns
`include "uce_regs.vh"
// Operation
// - With access enable clear the buffer manager leaves the endpoint alone.
// - Config bit 5 shows the data toggle and software cannot write it.
// - Toggle reads 0 when the next packet is DATA0 and 1 for DATA1.
// - While stall bit 3 and enable bit 7 are set every IN or OUT token to the endpoint gets STALL.
// - A SETUP packet clears the stall bit, and software may clear it too.
// - The endpoint interrupt needs config bit 2 and its enable bit (0 for OUT, 1 for IN) both set.
// - IN endpoint NAK bit set makes the engine answer IN tokens with NAK.
// - OUT endpoint NAK bit set makes the engine answer OUT tokens with NAK.
// - With IN NAK clear an IN token sends exactly the IN count of bytes.
// - The OUT count is a running tally of bytes received; a write with NAK clear zeroes it unless the open endpoint takes an OUT byte or OUT done in the same cycle.
// - After reset IN NAK is 1, OUT NAK is 0, counts and config bits are 0.
module uce_ctrl (
  input wire clock_i,
  input wire rst_i,
  input wire ce_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire setup_i,
  input wire in_token_i,
  input wire out_token_i,
  input wire in_ack_i,
  input wire out_byte_i,
  input wire out_done_i,
  output reg [1:0] in_hs_o,
  output reg [1:0] out_hs_o,
  output reg [6:0] in_len_o,
  output reg in_start_o,
  output reg in_bm_en_o,
  output reg out_bm_en_o,
  output reg in_toggle_o,
  output reg out_toggle_o,
  output reg irq_o
);
  // ****************************************************************
  // State
  // ****************************************************************
  reg [7:0] in_cfg;
  reg [7:0] out_cfg;
  reg in_nak;
  reg [6:0] in_cnt;
  reg out_nak;
  reg [6:0] out_cnt;
  reg [1:0] ep_irq_en;
  reg [1:0] irq_mask;
  wire [1:0] irq_status;
  wire in_tog;
  wire out_tog;
  wire [1:0] irq_set;
  wire [1:0] irq_clr;
  wire wr_in_cfg;
  wire wr_out_cfg;
  wire in_active;
  wire out_active;
  wire in_ok;
  wire out_ok;
  reg [7:0] next_rdata;
  localparam [7:0] in_count_rst = `UCE_RST_IN_COUNT;
  localparam [7:0] out_count_rst = `UCE_RST_OUT_COUNT;

  function sel;
    input [3:0] a;
    input [3:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  assign wr_in_cfg = wr_i & sel(addr_i, `UCE_OFS_IN_CONFIG);
  assign wr_out_cfg = wr_i & sel(addr_i, `UCE_OFS_OUT_CONFIG);
  assign in_active = in_cfg[`UCE_CFG_ENABLE];
  assign out_active = out_cfg[`UCE_CFG_ENABLE];
  assign in_ok = in_active & ~in_cfg[`UCE_CFG_STALL] & ~in_nak;
  assign out_ok = out_active & ~out_cfg[`UCE_CFG_STALL] & ~out_nak;

  // ****************************************************************
  // Data toggles
  // ****************************************************************
  uce_toggle u_in_toggle (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .setup_i(setup_i),
    .done_i(in_ack_i & in_ok),
    .toggle_o(in_tog)
  );

  uce_toggle u_out_toggle (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .setup_i(setup_i),
    .done_i(out_done_i & out_ok),
    .toggle_o(out_tog)
  );

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always @(posedge clock_i) begin
    if (rst_i) begin
      in_cfg <= `UCE_RST_CONFIG;
      out_cfg <= `UCE_RST_CONFIG;
    end else if (ce_i) begin
      if (wr_in_cfg) begin
        in_cfg <= wdata_i & `UCE_CFG_WR_MASK;
      end
      if (wr_out_cfg) begin
        out_cfg <= wdata_i & `UCE_CFG_WR_MASK;
      end
      if (setup_i) begin
        in_cfg[`UCE_CFG_STALL] <= 1'b0;
        out_cfg[`UCE_CFG_STALL] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Count registers
  // ****************************************************************
  always @(posedge clock_i) begin
    if (rst_i) begin
      in_nak <= in_count_rst[`UCE_CNT_NAK];
      in_cnt <= in_count_rst[`UCE_CNT_MSB:0];
      out_nak <= out_count_rst[`UCE_CNT_NAK];
      out_cnt <= out_count_rst[`UCE_CNT_MSB:0];
    end else if (ce_i) begin
      if (wr_i & sel(addr_i, `UCE_OFS_IN_COUNT)) begin
        in_nak <= wdata_i[`UCE_CNT_NAK];
        in_cnt <= wdata_i[`UCE_CNT_MSB:0];
      end else if (in_ack_i & in_ok) begin
        in_nak <= 1'b1;
      end
      if (out_done_i & out_ok) begin
        out_nak <= 1'b1;
      end else if (wr_i & sel(addr_i, `UCE_OFS_OUT_COUNT)) begin
        out_nak <= wdata_i[`UCE_CNT_NAK];
        if (!wdata_i[`UCE_CNT_NAK]) begin
          out_cnt <= 7'h00;
        end
      end
      if (out_byte_i & out_ok & ~out_done_i) begin
        out_cnt <= out_cnt + 7'h01;
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_set[`UCE_IRQ_OUT] = out_done_i & out_ok
    & out_cfg[`UCE_CFG_IRQ_EN] & ep_irq_en[`UCE_IRQ_OUT];
  assign irq_set[`UCE_IRQ_IN] = in_ack_i & in_ok
    & in_cfg[`UCE_CFG_IRQ_EN] & ep_irq_en[`UCE_IRQ_IN];
  assign irq_clr = (wr_i & sel(addr_i, `UCE_OFS_IRQ_STATUS)) ?
    wdata_i[1:0] : 2'h0;

  uce_sticky u_sticky (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(irq_set),
    .clr_i(irq_clr),
    .flag_o(irq_status)
  );

  always @(posedge clock_i) begin
    if (rst_i) begin
      ep_irq_en <= `UCE_RST_IRQ;
      irq_mask <= `UCE_RST_IRQ;
    end else if (ce_i) begin
      if (wr_i & sel(addr_i, `UCE_OFS_IRQ_ENABLE)) begin
        ep_irq_en <= wdata_i[1:0];
      end
      if (wr_i & sel(addr_i, `UCE_OFS_IRQ_MASK)) begin
        irq_mask <= wdata_i[1:0];
      end
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always @* begin
    next_rdata = 8'h00;
    case (addr_i)
      `UCE_OFS_IN_CONFIG: begin
        next_rdata = in_cfg;
        next_rdata[`UCE_CFG_TOGGLE] = in_tog;
      end
      `UCE_OFS_OUT_CONFIG: begin
        next_rdata = out_cfg;
        next_rdata[`UCE_CFG_TOGGLE] = out_tog;
      end
      `UCE_OFS_IN_COUNT: next_rdata = {in_nak, in_cnt};
      `UCE_OFS_OUT_COUNT: next_rdata = {out_nak, out_cnt};
      `UCE_OFS_IRQ_ENABLE: next_rdata = {6'h00, ep_irq_en};
      `UCE_OFS_IRQ_STATUS: next_rdata = {6'h00, irq_status};
      `UCE_OFS_IRQ_MASK: next_rdata = {6'h00, irq_mask};
      default: next_rdata = 8'h00;
    endcase
  end

  // ****************************************************************
  // Read data register
  // ****************************************************************
  always @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      // Holds the last read value until the next read strobe
      if (rd_i) begin
        rdata_o <= next_rdata;
      end
    end
  end

  // ****************************************************************
  // IN token answers
  // ****************************************************************
  always @(posedge clock_i) begin
    if (rst_i) begin
      in_hs_o <= `UCE_HS_NONE;
      in_len_o <= 7'h00;
      in_start_o <= 1'b0;
    end else if (ce_i) begin
      in_hs_o <= `UCE_HS_NONE;
      in_start_o <= 1'b0;
      if (in_token_i) begin
        if (!in_active) begin
          in_hs_o <= `UCE_HS_NONE;
        end else if (in_cfg[`UCE_CFG_STALL]) begin
          in_hs_o <= `UCE_HS_STALL;
        end else if (in_nak) begin
          in_hs_o <= `UCE_HS_NAK;
        end else begin
          in_start_o <= 1'b1;
          in_len_o <= in_cnt;
        end
      end
    end
  end

  // ****************************************************************
  // OUT token answers
  // ****************************************************************
  always @(posedge clock_i) begin
    if (rst_i) begin
      out_hs_o <= `UCE_HS_NONE;
    end else if (ce_i) begin
      out_hs_o <= `UCE_HS_NONE;
      if (out_token_i) begin
        if (!out_active) begin
          out_hs_o <= `UCE_HS_NONE;
        end else if (out_cfg[`UCE_CFG_STALL]) begin
          out_hs_o <= `UCE_HS_STALL;
        end else if (out_nak) begin
          out_hs_o <= `UCE_HS_NAK;
        end else begin
          out_hs_o <= `UCE_HS_ACK;
        end
      end
    end
  end

  // ****************************************************************
  // Level outputs
  // ****************************************************************
  always @(posedge clock_i) begin
    if (rst_i) begin
      in_bm_en_o <= 1'b0;
      out_bm_en_o <= 1'b0;
      in_toggle_o <= 1'b0;
      out_toggle_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      // Same cycle as the token answers, so both reflect one state
      in_bm_en_o <= in_active;
      out_bm_en_o <= out_active;
      in_toggle_o <= in_tog;
      out_toggle_o <= out_tog;
      irq_o <= |(irq_status & irq_mask);
    end
  end
endmodule // uce_ctrl

// ==== rtl/uce_regs.vh ====
// Offsets, fields, reset values and codes of the endpoint zero block
`ifndef UCE_REGS_VH
`define UCE_REGS_VH
// ****************************************************************
// Register offsets (byte addresses on the 8-bit register port)
// ****************************************************************
`define UCE_OFS_IN_CONFIG 4'h0
`define UCE_OFS_OUT_CONFIG 4'h1
`define UCE_OFS_IN_COUNT 4'h2
`define UCE_OFS_OUT_COUNT 4'h3
`define UCE_OFS_IRQ_ENABLE 4'h4
`define UCE_OFS_IRQ_STATUS 4'h5
`define UCE_OFS_IRQ_MASK 4'h6
// ****************************************************************
// Configuration register fields
// ****************************************************************
`define UCE_CFG_ENABLE 7
`define UCE_CFG_TOGGLE 5
`define UCE_CFG_STALL 3
`define UCE_CFG_IRQ_EN 2
`define UCE_CFG_WR_MASK 8'h8C
// ****************************************************************
// Count register fields
// ****************************************************************
`define UCE_CNT_NAK 7
`define UCE_CNT_MSB 6
// ****************************************************************
// Reset values
// ****************************************************************
`define UCE_RST_CONFIG 8'h00
`define UCE_RST_IN_COUNT 8'h80
`define UCE_RST_OUT_COUNT 8'h00
`define UCE_RST_IRQ 2'h0
// ****************************************************************
// Status bits and handshake codes
// ****************************************************************
`define UCE_IRQ_OUT 0
`define UCE_IRQ_IN 1
`define UCE_HS_ACK 2'h1
`define UCE_HS_NAK 2'h2
`define UCE_HS_STALL 2'h3
`define UCE_HS_NONE 2'h0
`endif

// ==== rtl/uce_toggle.v ====
// Data toggle tracker for one control endpoint
`timescale 1ns/1ns
`include "uce_regs.vh"
module uce_toggle (
  input wire clock_i,
  input wire rst_i,
  input wire ce_i,
  input wire setup_i,
  input wire done_i,
  output reg toggle_o
);
  // ****************************************************************
  // Toggle state
  // ****************************************************************
  always @(posedge clock_i) begin
    if (rst_i) begin
      toggle_o <= 1'b0;
    end else if (ce_i) begin
      if (setup_i) begin
        toggle_o <= 1'b1;
      end else if (done_i) begin
        toggle_o <= ~toggle_o;
      end
    end
  end
endmodule // uce_toggle

// ==== rtl/uce_sticky.v ====
// Sticky event flags with write-one-to-clear, set wins over clear
`timescale 1ns/1ns
`include "uce_regs.vh"
module uce_sticky (
  input wire clock_i,
  input wire rst_i,
  input wire ce_i,
  input wire [1:0] set_i,
  input wire [1:0] clr_i,
  output reg [1:0] flag_o
);
  wire [1:0] next_flag;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_flag
      // A new event in the clearing cycle keeps the flag set
      assign next_flag[g] = set_i[g] | (flag_o[g] & ~clr_i[g]);
    end
  endgenerate

  always @(posedge clock_i) begin
    if (rst_i) begin
      flag_o <= `UCE_RST_IRQ;
    end else if (ce_i) begin
      flag_o <= next_flag;
    end
  end
endmodule // uce_sticky

// ==== dv/uce_host_model.sv ====
// Host-side model issuing tokens, handshakes and OUT bytes
`timescale 1ns/1ns
module uce_host_model (
  input wire clock_i,
  output logic [5:0] ev_o
);
  // ****************************************************************
  // Event pulses: 0 setup, 1 IN token, 2 OUT token, 3 IN ack,
  // 4 OUT byte, 5 OUT done
  // ****************************************************************
  initial ev_o = 6'h00;
  task fire(input logic [5:0] m);
    @(posedge clock_i);
    ev_o <= m;
    @(posedge clock_i);
    ev_o <= 6'h00;
  endtask
  // OUT data stage of n bytes with idle gaps, then end of packet
  task bytes(input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge clock_i);
      fire(6'h10);
    end
    fire(6'h20);
  endtask
endmodule // uce_host_model

// ==== dv/uce_ctrl_asserts.sv ====
// Port assertions for the endpoint zero control block
`timescale 1ns/1ns
module uce_ctrl_asserts (
  input wire clock_i,
  input wire rst_i,
  input wire setup_i,
  input wire in_token_i,
  input wire out_token_i,
  input wire in_ack_i,
  input wire out_done_i,
  input wire [1:0] in_hs_o,
  input wire [1:0] out_hs_o,
  input wire in_start_o,
  input wire in_bm_en_o,
  input wire out_bm_en_o,
  input wire in_toggle_o,
  input wire out_toggle_o
);
  // ****************************************************************
  // Handshake and toggle relations
  // ****************************************************************
  wire in_cause = setup_i | in_ack_i;
  wire out_cause = setup_i | out_done_i;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  property p_in_hs;
    in_hs_o != 2'h0 |-> $past(in_token_i);
  endproperty
  a_in_hs: assert property (p_in_hs)
    else $error("IN answer without token");
  property p_in_act;
    (in_hs_o != 2'h0 || in_start_o) |-> in_bm_en_o;
  endproperty
  a_in_act: assert property (p_in_act)
    else $error("inactive IN endpoint answered");
  property p_in_start;
    in_start_o |-> $past(in_token_i) && in_hs_o == 2'h0;
  endproperty
  a_in_start: assert property (p_in_start)
    else $error("IN data start without token");
  property p_out_hs;
    out_hs_o != 2'h0 |-> $past(out_token_i);
  endproperty
  a_out_hs: assert property (p_out_hs)
    else $error("OUT answer without token");
  property p_out_act;
    out_hs_o != 2'h0 |-> out_bm_en_o;
  endproperty
  a_out_act: assert property (p_out_act)
    else $error("inactive OUT endpoint answered");
  property p_setup;
    setup_i |-> ##[1:2] (in_toggle_o && out_toggle_o);
  endproperty
  a_setup: assert property (p_setup)
    else $error("setup did not force DATA1");
  property p_in_tog;
    $changed(in_toggle_o) |-> $past(in_cause) || $past(in_cause, 2);
  endproperty
  a_in_tog: assert property (p_in_tog)
    else $error("IN toggle moved without cause");
  property p_out_tog;
    $changed(out_toggle_o) |-> $past(out_cause) || $past(out_cause, 2);
  endproperty
  a_out_tog: assert property (p_out_tog)
    else $error("OUT toggle moved without cause");
endmodule // uce_ctrl_asserts
bind uce_ctrl uce_ctrl_asserts u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .setup_i(setup_i),
  .in_token_i(in_token_i), .out_token_i(out_token_i),
  .in_ack_i(in_ack_i), .out_done_i(out_done_i), .in_hs_o(in_hs_o),
  .out_hs_o(out_hs_o), .in_start_o(in_start_o), .in_bm_en_o(in_bm_en_o),
  .out_bm_en_o(out_bm_en_o), .in_toggle_o(in_toggle_o),
  .out_toggle_o(out_toggle_o)
);

// ==== dv/uce_ctrl_tb_top.sv ====
// Self-checking bench for the endpoint zero control block
`timescale 1ns/1ns
`include "uce_regs.vh"
module uce_ctrl_tb_top;
  logic clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, d;
  logic [5:0] ev;
  logic [1:0] in_hs_o, out_hs_o;
  logic [6:0] in_len_o;
  logic in_start_o, in_bm_en_o, out_bm_en_o, in_toggle_o, out_toggle_o;
  logic irq_o;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  logic [19:0] rows [0:5];
  always #25 clock_i = ~clock_i;
  uce_host_model host (.clock_i(clock_i), .ev_o(ev));
  uce_ctrl dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .setup_i(ev[0]), .in_token_i(ev[1]),
    .out_token_i(ev[2]), .in_ack_i(ev[3]), .out_byte_i(ev[4]),
    .out_done_i(ev[5]), .in_hs_o(in_hs_o), .out_hs_o(out_hs_o),
    .in_len_o(in_len_o), .in_start_o(in_start_o),
    .in_bm_en_o(in_bm_en_o), .out_bm_en_o(out_bm_en_o),
    .in_toggle_o(in_toggle_o), .out_toggle_o(out_toggle_o),
    .irq_o(irq_o));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task print_verdict;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task ht(input logic [5:0] m);
    host.fire(m);
    #1;
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict;
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rows = '{{`UCE_OFS_IN_CONFIG, 8'h8C, 8'h8C},
      {`UCE_OFS_OUT_CONFIG, 8'h84, 8'h84},
      {`UCE_OFS_IN_COUNT, 8'h40, 8'h40},
      {`UCE_OFS_OUT_COUNT, 8'h80, 8'h80},
      {`UCE_OFS_OUT_COUNT, 8'h00, 8'h00},
      {4'h9, 8'hFF, 8'h00}};
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16]);
      chk(rows[i][7:0], d);
    end
    ht(6'h02);
    chk(8'h03, {6'h00, in_hs_o});
    ht(6'h01);
    rd(`UCE_OFS_IN_CONFIG);
    chk(8'hA4, d);
    ht(6'h02);
    chk(8'hC0, {in_start_o, in_len_o});
    ht(6'h08);
    ht(6'h02);
    chk(8'h02, {6'h00, in_hs_o});
    chk(8'h00, {7'h00, in_toggle_o});
    wr(`UCE_OFS_IRQ_ENABLE, 8'h03);
    wr(`UCE_OFS_IRQ_MASK, 8'h01);
    ht(6'h04);
    chk(8'h01, {6'h00, out_hs_o});
    host.bytes(3, 2);
    rd(`UCE_OFS_OUT_COUNT);
    chk(8'h83, d);
    chk(8'h00, {7'h00, out_toggle_o});
    chk(8'h01, {7'h00, irq_o});
    ht(6'h04);
    chk(8'h02, {6'h00, out_hs_o});
    wr(`UCE_OFS_IRQ_STATUS, 8'h01);
    rd(`UCE_OFS_IRQ_STATUS);
    chk(8'h00, {7'h00, irq_o});
    wr(`UCE_OFS_OUT_CONFIG, 8'h80);
    wr(`UCE_OFS_OUT_COUNT, 8'h00);
    ht(6'h04);
    host.bytes(1, 0);
    rd(`UCE_OFS_OUT_COUNT);
    chk(8'h81, d);
    chk(8'h00, {7'h00, irq_o});
    wr(`UCE_OFS_OUT_CONFIG, 8'h88);
    ht(6'h04);
    chk(8'h03, {6'h00, out_hs_o});
    wr(`UCE_OFS_OUT_CONFIG, 8'h80);
    ht(6'h04);
    chk(8'h02, {6'h00, out_hs_o});
    wr(`UCE_OFS_IN_CONFIG, 8'h00);
    ht(6'h02);
    chk(8'h00, {in_start_o, in_hs_o, 5'h00});
    chk(8'h01, {6'h00, in_bm_en_o, out_bm_en_o});
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(4'(i));
      chk((i == 2) ? 8'h80 : 8'h00, d);
    end
    print_verdict;
  end
endmodule // uce_ctrl_tb_top
